//--- verilog/cct_pkg.sv
// Shared constants, policy codes and controller states for the cache
// update and coherency controller.
// Assumes a 32-bit byte address split into select, tag, index, offset.
package cct_pkg;

  // Address and data geometry
  localparam int ADDR_W = 32; // Processor byte address width
  localparam int DATA_W = 32; // One block is one 32-bit word
  localparam int BE_W = 4; // Byte enables per block
  localparam int OFF_W = 2; // Byte offset bits inside a block
  localparam int IDX_W = 14; // Cache index bits
  localparam int TAG_W = 8; // Stored tag bits
  localparam int SEL_LSB = OFF_W + IDX_W + TAG_W; // First select bit
  localparam int SEL_W = ADDR_W - SEL_LSB; // Chip-select field width

  // Update policy codes
  localparam logic [1:0] POL_WT = 2'h0; // Plain write-through
  localparam logic [1:0] POL_BWT = 2'h1; // Buffered write-through
  localparam logic [1:0] POL_WB = 2'h2; // Write-back

  // Default non-cacheable select decode
  localparam logic [7:0] NC_SEL_VAL_RST = 8'hff; // Select value
  localparam logic [7:0] NC_SEL_MASK_RST = 8'h00; // Zero mask: every address non-cacheable

  // Reset values
  localparam logic [IDX_W-1:0] IDX_RST = 14'h0000; // Walk start
  localparam logic [IDX_W-1:0] IDX_LAST = 14'h3fff; // Walk end
  localparam logic [BE_W-1:0] BE_ALL = 4'hf; // Full block write

  // Controller states
  typedef enum logic [3:0] {
    S_IDLE, S_LOOK, S_VICT, S_FILL, S_SETTLE, S_MEMW, S_NCRD,
    S_WALK_RD, S_WALK_CHK, S_WALK_WB
  } cct_state_e;

endpackage : cct_pkg

//--- verilog/cct_store_if.sv
// Port bundle between the controller and its tag and data store.
// Assumes one registered read port and one byte-enabled write port.
`timescale 1ns/1ns
interface cct_store_if
  import cct_pkg::*;
;
  logic [IDX_W-1:0] rd_idx; // Index read every cycle
  logic [TAG_W-1:0] rd_tag; // Stored tag, one cycle later
  logic rd_valid; // Block holds live data
  logic rd_alt; // Block newer than memory
  logic [DATA_W-1:0] rd_data; // Stored block data
  logic wr_en; // Write strobe
  logic [IDX_W-1:0] wr_idx; // Index written
  logic [TAG_W-1:0] wr_tag; // Tag written
  logic wr_valid; // Valid flag written
  logic wr_alt; // Altered flag written
  logic [DATA_W-1:0] wr_data; // Data written
  logic [BE_W-1:0] wr_be; // Data bytes written

  // Controller side
  modport ctl (
    output rd_idx, wr_en, wr_idx, wr_tag, wr_valid, wr_alt, wr_data,
    output wr_be,
    input rd_tag, rd_valid, rd_alt, rd_data
  );

  // Store side
  modport mem (
    input rd_idx, wr_en, wr_idx, wr_tag, wr_valid, wr_alt, wr_data,
    input wr_be,
    output rd_tag, rd_valid, rd_alt, rd_data
  );

endinterface : cct_store_if

//--- verilog/cct_tag_store.sv
// Tag, flag and data arrays of the direct-mapped cache.
// Assumes the controller clears every entry by a walk after reset,
// so the arrays themselves carry no reset.
`timescale 1ns/1ns
module cct_tag_store
  import cct_pkg::*;
(
  input wire logic ref_clk,
  cct_store_if.mem st
);

  // Arrays: altered flag kept beside the tag
  logic [TAG_W-1:0] tag_mem [2**IDX_W]; // Address tags
  logic valid_mem [2**IDX_W]; // Valid flags
  logic alt_mem [2**IDX_W]; // Altered flags

  ////////////////////////////////////////////////////////////////////////
  // Tag and flag write, registered read (read before write)
  always_ff @(posedge ref_clk)
  begin
    if (st.wr_en)
    begin
      tag_mem[st.wr_idx] <= st.wr_tag;
      valid_mem[st.wr_idx] <= st.wr_valid;
      alt_mem[st.wr_idx] <= st.wr_alt;
    end
    st.rd_tag <= tag_mem[st.rd_idx];
    st.rd_valid <= valid_mem[st.rd_idx];
    st.rd_alt <= alt_mem[st.rd_idx];
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte lanes, each its own array so no two processes share one
  for (genvar b = 0; b < BE_W; b++)
  begin : g_lane
    logic [7:0] lane_mem [2**IDX_W]; // One byte lane of block data
    always_ff @(posedge ref_clk)
    begin
      if (st.wr_en && st.wr_be[b])
        lane_mem[st.wr_idx] <= st.wr_data[8*b +: 8];
      st.rd_data[8*b +: 8] <= lane_mem[st.rd_idx];
    end
  end

endmodule : cct_tag_store

//--- verilog/cct_ctrl.sv
// Cache update and coherency controller, direct mapped, one word blocks.
// Assumes processor, DMA and memory logic share ref_clk; requests are
// held until their one-cycle acknowledge.
//
// Operation
// (RULE_01) Buffered mode: buffer write, release processor early
// (RULE_02) Read hits served while buffer drains
// (RULE_03) Second write stalls while buffer full
// (RULE_04) Read miss waits for buffer drain
// (RULE_05) Each block keeps altered flag beside tag
// (RULE_06) Write-back write sets altered flag
// (RULE_07) Altered victim copied out before refill
// (RULE_08) Victim address from stored tag and index
// (RULE_09) Altered blocks written back before DMA access
// (RULE_10) Transparent mode routes DMA through cache
// (RULE_11) Non-cacheable accesses miss, never allocate
// (RULE_12) Non-cacheable from chip select or select bits
// (RULE_13) Flush writes back altered, then invalidates all
// (RULE_14) After flush every access misses until refilled
// (RULE_15) System flushes caches before shared memory writes
// (RULE_16) Arbitrate processor and DMA in transparent mode
// (RULE_17) Direct DMA leaves processor hits unhindered
// (RULE_18) Integrator may mix coherency mechanisms per region
// (RULE_19) Write-through copies each write to memory
// (RULE_20) Miss fetches block and replaces stored tag
// (RULE_21) Update policy fixed by parameter
// (RULE_22) Reset invalidates cache, empties write buffer
`timescale 1ns/1ns
module cct_ctrl
  import cct_pkg::*;
#(
  parameter logic [1:0] POLICY = POL_WT, // Update policy RULE_21
  parameter bit DMA_THRU = 1'b1, // DMA routed through cache
  parameter logic [SEL_W-1:0] NC_SEL_VAL = NC_SEL_VAL_RST,
  parameter logic [SEL_W-1:0] NC_SEL_MASK = NC_SEL_MASK_RST
)
(
  input wire logic ref_clk,
  input wire logic rst,
  // Processor side
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [DATA_W-1:0] cpu_wdata,
  input wire logic [BE_W-1:0] cpu_be,
  input wire logic cpu_nc_cs,
  output logic cpu_ack_q,
  output logic [DATA_W-1:0] cpu_rdata_q,
  // Second bus master
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [ADDR_W-1:0] dma_addr,
  input wire logic [DATA_W-1:0] dma_wdata,
  input wire logic [BE_W-1:0] dma_be,
  output logic dma_ack_q,
  output logic [DATA_W-1:0] dma_rdata_q,
  output logic dma_grant_q,
  // Main memory
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [ADDR_W-1:0] mem_addr_q,
  output logic [DATA_W-1:0] mem_wdata_q,
  output logic [BE_W-1:0] mem_be_q,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  // Flush control
  input wire logic flush_req,
  output logic busy_q
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode helpers
  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[OFF_W +: IDX_W];
  endfunction : idx_of

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    return a[OFF_W+IDX_W +: TAG_W];
  endfunction : tag_of

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  cct_store_if st (); // Store port bundle
  cct_state_e state_q; // Controller state
  logic req_dma_q; // Latched request came from DMA
  logic req_we_q; // Latched request is a write
  logic req_nc_q; // Latched request is non-cacheable
  logic [ADDR_W-1:0] req_addr_q; // Latched address
  logic [DATA_W-1:0] req_wdata_q; // Latched write data
  logic [BE_W-1:0] req_be_q; // Latched byte enables
  logic last_dma_q; // DMA won the last arbitration
  logic [IDX_W-1:0] walk_idx_q; // Flush walk index
  logic walk_init_q; // Walk is the reset clear, no copy-out
  logic walk_dma_q; // Walk precedes a DMA grant
  logic flush_pend_q; // Flush requested, not yet started
  logic wb_valid_q; // Write buffer holds a write
  logic [ADDR_W-1:0] wb_addr_q; // Buffered address
  logic [DATA_W-1:0] wb_data_q; // Buffered data
  logic [BE_W-1:0] wb_be_q; // Buffered byte enables
  logic drain_q; // Memory cycle belongs to the buffer
  logic cpu_take; // Processor asks, not just acknowledged
  logic dma_take; // DMA asks through the cache
  logic pick_dma; // Arbitration result
  logic [ADDR_W-1:0] pick_addr; // Address of the chosen request
  logic hit; // Tag match on a live block
  logic mem_go; // Controller may start a memory cycle
  logic mem_done; // Controller memory cycle finished
  logic is_wb; // Write-back policy
  logic is_bwt; // Buffered write-through policy

  assign is_wb = (POLICY == POL_WB);
  assign is_bwt = (POLICY == POL_BWT);

  cct_tag_store u_store (
    .ref_clk(ref_clk),
    .st(st.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // Arbitration: alternate winner when both ask (RULE_16)
  always_comb
  begin
    cpu_take = cpu_req && !cpu_ack_q;
    dma_take = DMA_THRU && dma_req && !dma_ack_q; // RULE_10
    pick_dma = dma_take && (!cpu_take || !last_dma_q); // RULE_16
    pick_addr = pick_dma ? dma_addr : cpu_addr;
  end

  // Hit test; invalid blocks after a flush never match (RULE_14)
  assign hit = st.rd_valid && (st.rd_tag == tag_of(req_addr_q));

  // Memory path is free of DMA and of the write buffer
  // Waiting on the buffer covers the miss; the write stall is held in S_LOOK
  assign mem_go = !mem_req_q && !dma_grant_q && !wb_valid_q; // RULE_04
  assign mem_done = mem_req_q && mem_ack && !drain_q;

  ////////////////////////////////////////////////////////////////////////
  // Store port drive
  always_comb
  begin
    st.rd_idx = idx_of(req_addr_q);
    st.wr_en = 1'b0;
    st.wr_idx = idx_of(req_addr_q);
    st.wr_tag = tag_of(req_addr_q);
    st.wr_valid = 1'b1;
    st.wr_alt = 1'b0; // Altered bit kept beside the tag RULE_05
    st.wr_data = req_wdata_q;
    st.wr_be = req_be_q;
    case (state_q)
      S_IDLE:
        st.rd_idx = idx_of(pick_addr);
      S_LOOK:
        // Write hit updates the block; stalled buffered writes wait
        if (req_we_q && hit && !req_nc_q && !(is_bwt && wb_valid_q))
        begin
          st.wr_en = 1'b1;
          st.wr_alt = is_wb; // RULE_06
        end
      S_FILL:
        // Refill overwrites data and tag, clean (RULE_20)
        if (mem_done)
        begin
          st.wr_en = 1'b1;
          st.wr_data = mem_rdata;
          st.wr_be = BE_ALL;
        end
      S_WALK_RD, S_WALK_WB:
      begin
        st.rd_idx = walk_idx_q;
        st.wr_idx = walk_idx_q;
        st.wr_valid = 1'b0;
        st.wr_en = (state_q == S_WALK_WB) && mem_done; // RULE_13
      end
      S_WALK_CHK:
      begin
        st.rd_idx = walk_idx_q;
        st.wr_idx = walk_idx_q;
        st.wr_valid = 1'b0; // Invalidate and clear altered RULE_22
        st.wr_en = walk_init_q || !(is_wb && st.rd_valid && st.rd_alt);
      end
      default:
        st.wr_en = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending flush request, set wins over the start of the walk
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      flush_pend_q <= 1'b0;
    else if (flush_req)
      flush_pend_q <= 1'b1;
    else if (state_q == S_IDLE && !mem_req_q && !wb_valid_q)
      flush_pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Controller sequence, memory port and write buffer
  // One block because memory cycles are shared by sequence and buffer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= S_WALK_RD; // Clear all entries first RULE_22
      walk_idx_q <= IDX_RST;
      walk_init_q <= 1'b1;
      walk_dma_q <= 1'b0;
      busy_q <= 1'b1;
      wb_valid_q <= 1'b0; // RULE_22
      wb_addr_q <= '0;
      wb_data_q <= '0;
      wb_be_q <= '0;
      drain_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      mem_be_q <= '0;
      cpu_ack_q <= 1'b0;
      cpu_rdata_q <= '0;
      dma_ack_q <= 1'b0;
      dma_rdata_q <= '0;
      dma_grant_q <= 1'b0;
      last_dma_q <= 1'b0;
      req_dma_q <= 1'b0;
      req_we_q <= 1'b0;
      req_nc_q <= 1'b0;
      req_addr_q <= '0;
      req_wdata_q <= '0;
      req_be_q <= '0;
    end
    else
    begin
      cpu_ack_q <= 1'b0;
      dma_ack_q <= 1'b0;
      // Direct DMA released when it stops asking
      if (dma_grant_q && !dma_req)
        dma_grant_q <= 1'b0;
      case (state_q)
        S_IDLE:
          if (flush_pend_q && !mem_req_q && !wb_valid_q)
          begin
            state_q <= S_WALK_RD; // RULE_13
            walk_idx_q <= IDX_RST;
            busy_q <= 1'b1;
          end
          else if (!DMA_THRU && dma_req && !dma_grant_q && !mem_req_q
                   && !wb_valid_q)
          begin
            if (is_wb)
            begin
              state_q <= S_WALK_RD; // Copy out before grant RULE_09
              walk_idx_q <= IDX_RST;
              walk_dma_q <= 1'b1;
              busy_q <= 1'b1;
            end
            else
              dma_grant_q <= 1'b1;
          end
          else if (cpu_take || dma_take)
          begin
            state_q <= S_LOOK;
            last_dma_q <= pick_dma;
            req_dma_q <= pick_dma;
            req_we_q <= pick_dma ? dma_we : cpu_we;
            req_addr_q <= pick_addr;
            req_wdata_q <= pick_dma ? dma_wdata : cpu_wdata;
            req_be_q <= pick_dma ? dma_be : cpu_be;
            // Chip select or masked select bits RULE_12
            req_nc_q <= (!pick_dma && cpu_nc_cs)
              || ((pick_addr[SEL_LSB +: SEL_W] & NC_SEL_MASK)
                  == (NC_SEL_VAL & NC_SEL_MASK));
          end
        S_LOOK:
          if (!req_we_q && hit && !req_nc_q)
          begin
            // Read hit, no wait for buffer or DMA RULE_02 RULE_17
            state_q <= S_IDLE;
            cpu_ack_q <= !req_dma_q;
            dma_ack_q <= req_dma_q;
            cpu_rdata_q <= st.rd_data;
            dma_rdata_q <= st.rd_data;
          end
          else if (!req_we_q && (req_nc_q || !is_wb))
            state_q <= req_nc_q ? S_NCRD : S_FILL; // RULE_11
          else if (is_bwt)
          begin
            // Take the write into the buffer, release early RULE_01
            if (!wb_valid_q) // Full buffer holds the writer RULE_03
            begin
              wb_valid_q <= 1'b1;
              wb_addr_q <= req_addr_q;
              wb_data_q <= req_wdata_q;
              wb_be_q <= req_be_q;
              state_q <= S_IDLE;
              cpu_ack_q <= !req_dma_q;
              dma_ack_q <= req_dma_q;
            end
          end
          else if (is_wb && hit && !req_nc_q)
          begin
            state_q <= S_IDLE; // Altered set by store write RULE_06
            cpu_ack_q <= !req_dma_q;
            dma_ack_q <= req_dma_q;
          end
          else if (is_wb && !req_nc_q)
            // Any miss allocates; dirty victim goes out first RULE_07
            state_q <= (st.rd_valid && st.rd_alt) ? S_VICT : S_FILL;
          else
            state_q <= S_MEMW; // Copy write to memory RULE_19
        S_VICT:
          if (mem_go)
          begin
            // Address rebuilt from stored tag and index RULE_08
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b1;
            mem_addr_q <= {req_addr_q[SEL_LSB +: SEL_W], st.rd_tag,
                           idx_of(req_addr_q), {OFF_W{1'b0}}};
            mem_wdata_q <= st.rd_data;
            mem_be_q <= BE_ALL;
          end
          else if (mem_done)
          begin
            mem_req_q <= 1'b0;
            state_q <= S_FILL; // Load only after copy-out RULE_07
          end
        S_FILL:
          if (mem_go)
          begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= {req_addr_q[ADDR_W-1:OFF_W], {OFF_W{1'b0}}};
            mem_be_q <= BE_ALL;
          end
          else if (mem_done)
          begin
            mem_req_q <= 1'b0;
            state_q <= S_SETTLE; // Redo the access on the new block
          end
        S_SETTLE:
          state_q <= S_LOOK; // Store read catches the refill
        S_MEMW, S_NCRD:
          if (mem_go)
          begin
            mem_req_q <= 1'b1;
            mem_we_q <= (state_q == S_MEMW);
            mem_addr_q <= req_addr_q;
            mem_wdata_q <= req_wdata_q;
            mem_be_q <= req_be_q;
          end
          else if (mem_done)
          begin
            mem_req_q <= 1'b0;
            state_q <= S_IDLE; // Acknowledged after memory RULE_19
            cpu_ack_q <= !req_dma_q;
            dma_ack_q <= req_dma_q;
            cpu_rdata_q <= mem_rdata;
            dma_rdata_q <= mem_rdata;
          end
        S_WALK_RD:
          state_q <= S_WALK_CHK;
        S_WALK_CHK:
          if (!walk_init_q && is_wb && st.rd_valid && st.rd_alt)
            state_q <= S_WALK_WB; // Altered block goes out RULE_13
          else if (walk_idx_q == IDX_LAST)
          begin
            state_q <= S_IDLE;
            busy_q <= 1'b0;
            walk_init_q <= 1'b0;
            walk_dma_q <= 1'b0;
            dma_grant_q <= walk_dma_q && dma_req; // RULE_09
          end
          else
          begin
            walk_idx_q <= walk_idx_q + 1'b1;
            state_q <= S_WALK_RD;
          end
        S_WALK_WB:
          if (mem_go)
          begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b1;
            mem_addr_q <= {req_addr_q[SEL_LSB +: SEL_W], st.rd_tag,
                           walk_idx_q, {OFF_W{1'b0}}};
            mem_wdata_q <= st.rd_data;
            mem_be_q <= BE_ALL;
          end
          else if (mem_done)
          begin
            mem_req_q <= 1'b0;
            state_q <= S_WALK_RD; // Reread, the entry is now invalid and clean
          end
        default:
          state_q <= S_IDLE;
      endcase
      // Buffer drain shares the memory port; never overlaps the
      // sequence, which only starts cycles with the buffer empty
      if (wb_valid_q && !mem_req_q && !dma_grant_q)
      begin
        mem_req_q <= 1'b1; // RULE_01
        mem_we_q <= 1'b1;
        mem_addr_q <= wb_addr_q;
        mem_wdata_q <= wb_data_q;
        mem_be_q <= wb_be_q;
        drain_q <= 1'b1;
      end
      else if (drain_q && mem_ack)
      begin
        mem_req_q <= 1'b0;
        drain_q <= 1'b0;
        wb_valid_q <= 1'b0; // Buffer free again RULE_03
      end
    end
  end

endmodule : cct_ctrl

//--- verif/cct_ctrl_assertions.sv
// Port checker for the cache controller top module.
// Assumes one clock domain, synchronous active-high reset.
`timescale 1ns/1ns
module cct_ctrl_assertions
  import cct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cpu_req,
  input wire logic cpu_ack_q,
  input wire logic dma_ack_q,
  input wire logic dma_grant_q,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic [ADDR_W-1:0] mem_addr_q,
  input wire logic [DATA_W-1:0] mem_wdata_q,
  input wire logic [BE_W-1:0] mem_be_q,
  input wire logic mem_ack,
  input wire logic busy_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Reset must quiet every request and start the clearing walk
  property p_rst; disable iff (1'b0) rst |=> busy_q && !mem_req_q; endproperty
  a_rst: assert property (p_rst)
    else $error("reset left outputs active");
  // Memory cycle held whole until acknowledged
  property p_mem_hold; mem_req_q && !mem_ack |=> mem_req_q &&
    $stable(mem_addr_q) && $stable(mem_we_q) && $stable(mem_wdata_q) &&
    $stable(mem_be_q); endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request changed early");
  property p_mem_drop; mem_req_q && mem_ack |=> !mem_req_q; endproperty
  a_mem_drop: assert property (p_mem_drop)
    else $error("memory request kept after ack");
  property p_cpu_pulse; cpu_ack_q |=> !cpu_ack_q; endproperty
  a_cpu_pulse: assert property (p_cpu_pulse)
    else $error("processor ack longer than one cycle");
  property p_dma_pulse; dma_ack_q |=> !dma_ack_q; endproperty
  a_dma_pulse: assert property (p_dma_pulse)
    else $error("dma ack longer than one cycle");
  // One path to memory, so one master answered at a time
  property p_one_ack; !(cpu_ack_q && dma_ack_q); endproperty
  a_one_ack: assert property (p_one_ack)
    else $error("both masters acked together");
  property p_busy_quiet; busy_q && $past(busy_q) |-> !cpu_ack_q; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("access answered during walk");
  // Routed mode never hands memory to the second master
  property p_no_grant; !dma_grant_q; endproperty
  a_no_grant: assert property (p_no_grant)
    else $error("grant raised in routed mode");
  // Bound holds only while the memory partner answers within a few cycles
  property p_cpu_done; $rose(cpu_req) && !busy_q |-> ##[2:200] cpu_ack_q;
  endproperty
  a_cpu_done: assert property (p_cpu_done)
    else $error("processor access never answered");
  property p_ack_cause; cpu_ack_q |-> $past(cpu_req) && $past(cpu_req, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without held request");
endmodule : cct_ctrl_assertions

bind cct_ctrl cct_ctrl_assertions u_chk (.ref_clk, .rst, .cpu_req,
  .cpu_ack_q, .dma_ack_q, .dma_grant_q, .mem_req_q, .mem_we_q, .mem_addr_q,
  .mem_wdata_q, .mem_be_q, .mem_ack, .busy_q);

//--- verif/cct_mem_model.sv
// Behavioural main memory facing the controller.
// Assumes word-aligned requests held until the one-cycle ack.
`timescale 1ns/1ns
module cct_mem_model
  import cct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic [ADDR_W-1:0] mem_addr_q,
  input wire logic [DATA_W-1:0] mem_wdata_q,
  input wire logic [BE_W-1:0] mem_be_q,
  output logic mem_ack,
  output logic [DATA_W-1:0] mem_rdata
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]]; // Stored words
  int rd_cnt = 0; // Reads served
  int wt = 0; // Wait states spent
  bit slow = 1'b0; // Alternates prompt and slow answers
  logic [DATA_W-1:0] w; // Word being merged
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  ////////////////////////////////////////////////////////////////////////
  // Answer one request; data toggles when not valid, never holds
  always @(posedge ref_clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req_q && !mem_ack)
    begin
      if (wt < (slow ? 3 : 0))
        wt <= wt + 1;
      else
      begin
        mem_ack <= 1'b1;
        wt <= 0;
        slow <= !slow;
        w = mem.exists(mem_addr_q) ? mem[mem_addr_q] : 32'h5a5a5a5a;
        if (mem_we_q)
        begin
          for (int b = 0; b < BE_W; b++)
            if (mem_be_q[b])
              w[8*b+:8] = mem_wdata_q[8*b+:8];
          mem[mem_addr_q] = w;
        end
        else
        begin
          mem_rdata <= w;
          rd_cnt <= rd_cnt + 1;
        end
      end
    end
  end
endmodule : cct_mem_model

//--- verif/cct_ctrl_tb_top.sv
// Self-checking bench, write-back policy, dma routed through the cache.
// Assumes cct_mem_model as memory; select 80 decodes non-cacheable.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module cct_ctrl_tb_top
  import cct_pkg::*;
;
  localparam logic [ADDR_W-1:0] A = 32'h0012_0040; // Index 10
  localparam logic [ADDR_W-1:0] B = 32'h0044_0040; // Same index as A
  localparam logic [ADDR_W-1:0] C = 32'h0033_0080;
  localparam logic [ADDR_W-1:0] D = 32'h0055_0080; // Same index as C
  localparam logic [ADDR_W-1:0] N = 32'h8012_0040; // Non-cacheable
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cpu_req = 1'b0, cpu_we = 1'b0, cpu_nc_cs = 1'b0;
  logic dma_req = 1'b0, dma_we = 1'b0, flush_req = 1'b0;
  logic [ADDR_W-1:0] cpu_addr = 32'h0, dma_addr = 32'h0, mem_addr_q;
  logic [DATA_W-1:0] cpu_wdata = 32'h0, dma_wdata = 32'h0, cpu_rdata_q;
  logic [DATA_W-1:0] dma_rdata_q, mem_wdata_q, mem_rdata;
  logic [BE_W-1:0] cpu_be = BE_ALL, dma_be = BE_ALL, mem_be_q;
  logic cpu_ack_q, dma_ack_q, dma_grant_q, mem_req_q, mem_we_q;
  logic mem_ack, busy_q;
  int errors = 0, total_checks = 0, rc;
  logic [31:0] rs = 32'd48; // Generator state
  logic [31:0] r;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]]; // Expected memory
  logic [ADDR_W-1:0] pick [4] = '{A, B, C, D}; // Conflicting pairs
  ////////////////////////////////////////////////////////////////////////
  always #4 ref_clk = ~ref_clk;

  cct_ctrl #(.POLICY(POL_WB), .DMA_THRU(1'b1), .NC_SEL_VAL(8'h80),
    .NC_SEL_MASK(8'hff)) u_dut (.ref_clk, .rst, .cpu_req, .cpu_we,
    .cpu_addr, .cpu_wdata, .cpu_be, .cpu_nc_cs, .cpu_ack_q, .cpu_rdata_q,
    .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_be, .dma_ack_q,
    .dma_rdata_q, .dma_grant_q, .mem_req_q, .mem_we_q, .mem_addr_q,
    .mem_wdata_q, .mem_be_q, .mem_ack, .mem_rdata, .flush_req, .busy_q);
  cct_mem_model u_mem (.ref_clk, .mem_req_q, .mem_we_q, .mem_addr_q,
    .mem_wdata_q, .mem_be_q, .mem_ack, .mem_rdata);
  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  // One access by either master; reference updated or compared
  task automatic acc(input bit m, input bit we, input logic [31:0] a,
    input logic [31:0] d, input logic [3:0] be, input bit nc);
    int n;
    logic [DATA_W-1:0] w;
    n = 0;
    w = ref_mem.exists(a) ? ref_mem[a] : 32'h5a5a5a5a;
    @(negedge ref_clk);
    if (m)
    begin
      dma_req = 1'b1; dma_we = we; dma_addr = a; dma_wdata = d; dma_be = be;
    end
    else
    begin
      cpu_req = 1'b1; cpu_we = we; cpu_addr = a; cpu_wdata = d; cpu_be = be;
      cpu_nc_cs = nc;
    end
    do begin @(negedge ref_clk); n++; end
    while ((m ? dma_ack_q : cpu_ack_q) !== 1'b1 && n < 300);
    `CHK(m ? dma_ack_q : cpu_ack_q, 1'b1)
    if (m) dma_req = 1'b0;
    else cpu_req = 1'b0;
    if (we)
    begin
      for (int b = 0; b < BE_W; b++)
        if (be[b])
          w[8*b+:8] = d[8*b+:8];
      ref_mem[a] = w;
    end
    else
      `CHK(m ? dma_rdata_q : cpu_rdata_q, w)
  endtask : acc

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy_q !== lvl && n < lim) begin @(negedge ref_clk); n++; end
    `CHK(busy_q, lvl)
  endtask : wait_busy

  task print_verdict();
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    wait_busy(1'b0, 40000);
    acc(0, 1, A, xs(), BE_ALL, 0);
    rc = u_mem.rd_cnt;
    acc(0, 0, A, 32'h0, BE_ALL, 0);
    `CHK(u_mem.rd_cnt, rc)
    acc(0, 0, B, 32'h0, BE_ALL, 0);
    `CHK(u_mem.mem.exists(A), 1)
    `CHK(u_mem.mem[A], ref_mem[A])
    rc = u_mem.rd_cnt;
    repeat (2) acc(0, 0, N, 32'h0, BE_ALL, 0);
    `CHK(u_mem.rd_cnt, rc + 2)
    repeat (2) acc(0, 0, C, 32'h0, BE_ALL, 1);
    `CHK(u_mem.rd_cnt, rc + 4)
    // Both masters at once on one index
    fork
      acc(1, 1, B, xs(), BE_ALL, 0);
      acc(0, 0, A, 32'h0, BE_ALL, 0);
    join
    acc(0, 0, B, 32'h0, BE_ALL, 0);
    for (int i = 0; i < 24; i++)
    begin
      r = xs();
      acc(r[3], r[2], pick[r[1:0]], xs(), r[7:4] | 4'h1, 0);
    end
    @(negedge ref_clk);
    flush_req = 1'b1;
    @(negedge ref_clk);
    flush_req = 1'b0;
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 40000);
    foreach (ref_mem[k]) `CHK(u_mem.mem[k], ref_mem[k])
    rc = u_mem.rd_cnt;
    acc(0, 0, A, 32'h0, BE_ALL, 0);
    `CHK(u_mem.rd_cnt, rc + 1)
    print_verdict();
  end

  // Two clearing walks of about 33k cycles each, plus traffic
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end
endmodule : cct_ctrl_tb_top
